// file: bench/err_sum_tb.sv
/*
 self-checking bench for the error summary block: registers, flags, capture, vectors.
 assumes vec_target answers vectored requests; the cable is reported bad for one read only.
*/
`timescale 1ns/100ps
module err_sum_tb;
   import err_sum_pkg::*;
   logic clock = 1'b0, reset_n = 1'b0, cmd_accept = 1'b0, self_test_pass = 1'b0;
   logic cable_ok = 1'b1, dma_req = 1'b0, slow = 1'b0, error_irq, vec_irq_req, vec_ack;
   logic responder_lock, bus_addr_lock, loop_abort, read_error_reply, use_return_vector;
   logic [5:0] cmd_node = 6'h00;
   logic [3:0] cmd_code = 4'h0, vec_irq_type;
   logic [15:0] vec_irq_dest;
   logic [31:0] dma_addr = 32'h0, rdata;
   reg_req_s req = '0;
   fault_s fault = '0;
   xlate_mode_e xlate_mode = xlate_none;
   int miscompares = 0, checks_done = 0;
   // expected flags per fault field, highest field first, and which of them vector
   localparam logic [15:0] flg [16] = '{16'h2000, 16'h1000, 16'h0800, 16'h0400, 16'h0200,
      16'h0080, 16'h00C0, 16'h00C0, 16'h0080, 16'h0040, 16'h0020, 16'h0010, 16'h0008,
      16'h0004, 16'h0002, 16'h0001};
   localparam logic [15:0] vec_on = 16'h2FE0;
   localparam xlate_mode_e am [6] = '{xlate_none, xlate_none, xlate_40_4k, xlate_40_8k,
      xlate_40_8k, xlate_other};
   localparam logic [31:0] aa [6] = '{32'h2000_0000, 32'h1000_0000, 32'h1000_0000,
      32'h0200_0000, 32'h0100_0000, 32'h2200_0000};
   localparam logic [5:0] ae = 6'h0D;
   // fault positions that only vector on a DMA write
   localparam int qb [5] = '{15, 13, 5, 3, 1};
   err_sum dut_u (.clock(clock), .reset_n(reset_n), .req(req), .rdata(rdata),
      .cmd_accept(cmd_accept), .cmd_node(cmd_node), .cmd_code(cmd_code), .cable_ok(cable_ok),
      .self_test_pass(self_test_pass), .fault(fault), .dma_req(dma_req), .dma_addr(dma_addr),
      .xlate_mode(xlate_mode), .vec_ack(vec_ack), .error_irq(error_irq),
      .vec_irq_req(vec_irq_req), .vec_irq_dest(vec_irq_dest), .vec_irq_type(vec_irq_type),
      .responder_lock(responder_lock), .bus_addr_lock(bus_addr_lock), .loop_abort(loop_abort),
      .read_error_reply(read_error_reply), .use_return_vector(use_return_vector));
   vec_target target_u (.clock(clock), .reset_n(reset_n), .vec_irq_req(vec_irq_req),
      .slow(slow), .vec_ack(vec_ack));
   always #25 clock = ~clock;
   task conclude();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one-cycle write strobe, taken at the rising edge in between
   task wr(input logic [7:0] off, input logic [31:0] data);
      @(negedge clock);
      req = '{rd: 1'b0, wr: 1'b1, offset: off, wdata: data};
      @(negedge clock);
      req.wr = 1'b0;
   endtask
   // read data is combinational, so it settles within the same cycle
   task rchk(input logic [7:0] off, input logic [31:0] m, input logic [31:0] exp,
      input string what);
      @(negedge clock);
      req.offset = off;
      req.rd = 1'b1;
      #1 chk(rdata & m, exp, what);
   endtask
   task ev(input fault_s f, input logic acc);
      @(negedge clock);
      fault = f;
      cmd_accept = acc;
      @(negedge clock);
      fault = '0;
      cmd_accept = 1'b0;
   endtask
   task vwait();
      for (int n = 0; n < 20 && vec_irq_req !== 1'b0; n++) @(negedge clock);
      if (vec_irq_req !== 1'b0) begin
         miscompares++;
         conclude();
      end
   endtask
   // watchdog against a hang anywhere in the sequence
   initial begin
      repeat (5000) @(posedge clock);
      miscompares++;
      conclude();
   end
   initial begin
      repeat (8) @(negedge clock);
      reset_n = 1'b1;
      rchk(summary_offset, 32'hFFFF_FFFF, summary_reset, "summary");
      rchk(irq_mask_offset, 32'hFFFF_FFFF, 32'h0, "mask");
      rchk(8'h1C, 32'hFFFF_FFFF, 32'h0, "unmapped");
      cable_ok = 1'b0;
      rchk(summary_offset, 32'h8000_0000, 32'h0, "cable state");
      cable_ok = 1'b1;
      @(negedge clock);
      self_test_pass = 1'b1;
      @(negedge clock);
      self_test_pass = 1'b0;
      rchk(summary_offset, 32'hFFFF, 32'h0, "self test");
      wr(irq_mask_offset, 32'hFFFF_FFFF);
      wr(vector_dest_offset, 32'h0000_8001);
      rchk(irq_mask_offset, 32'hFFFF_FFFF, mask_writable, "mask bits");
      xlate_mode = xlate_40_8k;
      // every flag-setting fault kind alone: flag, interrupt, vector, clear
      for (int i = 0; i < 16; i++) begin
         slow = i[0];
         ev(fault_s'(18'h1 << (17 - i)), 1'b0);
         chk(vec_irq_req, vec_on[i], "vector request");
         if (vec_on[i]) chk({vec_irq_type, vec_irq_dest}, {write_fault_type, 16'h8001}, "vec");
         chk(error_irq, 1'b1, "error irq");
         rchk(summary_offset, 32'hFFFF, flg[i], "flag");
         wr(summary_offset, 32'hFFFF);
         rchk(summary_offset, 32'hFFFF, 32'h0, "flag clear");
         chk(error_irq, 1'b0, "irq drop");
         vwait();
      end
      ev('{bad_state: 1'b1, default: 1'b0}, 1'b0);
      ev('{power_event: 1'b1, default: 1'b0}, 1'b0);
      rchk(summary_offset, 32'hFFFF, 32'h00A0, "power ignored");
      ev('{buf_b_data_pe: 1'b1, default: 1'b0}, 1'b0);
      rchk(summary_offset, 32'hFFFF, 32'h40A4, "multiple");
      wr(summary_offset, 32'hFFFF);
      vwait();
      // capture, freeze on a responder failure, release after clear
      cmd_node = 6'h2A;
      cmd_code = 4'h5;
      ev('0, 1'b1);
      rchk(summary_offset, 32'h03FF_0000, 32'h02A5_0000, "node capture");
      cmd_node = 6'h15;
      cmd_code = 4'hA;
      ev('{io_write_fail: 1'b1, default: 1'b0}, 1'b1);
      chk(responder_lock, 1'b1, "responder lock");
      ev('0, 1'b1);
      rchk(summary_offset, 32'h03FF_0000, 32'h02A5_0000, "node frozen");
      wr(summary_offset, 32'hFFFF);
      ev('0, 1'b1);
      rchk(summary_offset, 32'h03FF_0000, 32'h015A_0000, "node release");
      vwait();
      // address checks per translation mode, failing transfer a write
      for (int i = 0; i < 6; i++) begin
         @(negedge clock);
         dma_req = 1'b1;
         xlate_mode = am[i];
         dma_addr = aa[i];
         fault.dma_write = 1'b1;
         @(negedge clock);
         dma_req = 1'b0;
         fault.dma_write = 1'b0;
         chk(vec_irq_req, ae[i], "address vector");
         chk(bus_addr_lock, ae[i], "address lock");
         rchk(summary_offset, 32'h0100, {23'h0, ae[i], 8'h0}, "bad address");
         wr(summary_offset, 32'hFFFF);
         vwait();
      end
      // translate faults ignored without translation
      xlate_mode = xlate_none;
      ev('{xlate_corr: 1'b1, xlate_fatal: 1'b1, default: 1'b0}, 1'b0);
      rchk(summary_offset, 32'hFFFF, 32'h0, "no translate flag");
      // write-qualified triggers do vector when the failing transfer is a DMA write
      xlate_mode = xlate_40_4k;
      for (int i = 0; i < 5; i++) begin
         ev(fault_s'((18'h1 << qb[i]) | 18'h1), 1'b0);
         chk(vec_irq_req, 1'b1, "write vector");
         wr(summary_offset, 32'hFFFF);
         vwait();
      end
      @(negedge clock);
      fault.io_read_pe = 1'b1;
      fault.loop_wr_parity = 1'b1;
      #1 chk(read_error_reply, 1'b1, "read error reply");
      chk(loop_abort, 1'b1, "loop abort");
      fault.dma_write = 1'b1;
      #1 chk(use_return_vector, 1'b1, "return vector");
      chk(read_error_reply, 1'b0, "no read error on vector read");
      @(negedge clock);
      fault = '0;
      wr(summary_offset, 32'hFFFF);
      vwait();
      // global enable off: no vector, mask still gates the error interrupt
      wr(irq_mask_offset, 32'h0000_0FFF);
      ev('{bad_state: 1'b1, default: 1'b0}, 1'b0);
      chk(vec_irq_req, 1'b0, "vector disabled");
      chk(error_irq, 1'b1, "irq masked on");
      wr(irq_mask_offset, 32'h0000_0F7F);
      chk(error_irq, 1'b0, "irq masked off");
      // a node reset in mid-run sets power loss again and clears the mask
      @(negedge clock);
      reset_n = 1'b0;
      @(negedge clock);
      reset_n = 1'b1;
      rchk(summary_offset, 32'hFFFF, 32'h0020, "reset power loss");
      chk(error_irq, 1'b0, "irq after reset");
      conclude();
   end
endmodule

// file: bench/vec_target.sv
/*
 system bus interrupt target that takes vectored error transactions.
 assumes vec_irq_req stands until acknowledged; slow makes the answer late.
*/
`timescale 1ns/100ps
module vec_target (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic vec_irq_req,
   input wire logic slow,
   output logic vec_ack
);
   logic [2:0] wait_ff;
   // wait four cycles when slow, none otherwise, while the request stands, then acknowledge for one cycle only
   always @(posedge clock) begin
      if (!reset_n || !vec_irq_req || vec_ack) begin
         wait_ff <= 3'h0;
         vec_ack <= 1'b0;
      end else if (wait_ff >= (slow ? 3'h4 : 3'h0)) begin
         vec_ack <= 1'b1;
      end else begin
         wait_ff <= wait_ff + 3'h1;
      end
   end
endmodule

// file: verilog/err_sum.sv
/*
 error summary, interrupt mask and vectored error-interrupt logic.
 assumes registers reach it through node-space reads/writes; datapath supplies fault pulses.
*/
`timescale 1ns/100ps
module err_sum (
   input wire logic clock,
   input wire logic reset_n,
   input wire err_sum_pkg::reg_req_s req,
   output logic [31:0] rdata,
   input wire logic cmd_accept,
   input wire logic [5:0] cmd_node,
   input wire logic [3:0] cmd_code,
   input wire logic cable_ok,
   input wire logic self_test_pass,
   input wire err_sum_pkg::fault_s fault,
   input wire logic dma_req,
   input wire logic [31:0] dma_addr,
   input wire err_sum_pkg::xlate_mode_e xlate_mode,
   input wire logic vec_ack,
   output logic error_irq,
   output logic vec_irq_req,
   output logic [15:0] vec_irq_dest,
   output logic [3:0] vec_irq_type,
   output logic responder_lock,
   output logic bus_addr_lock,
   output logic loop_abort,
   output logic read_error_reply,
   output logic use_return_vector
);
   import err_sum_pkg::*;

   logic [15:0] flags_ff, nxt_flags;
   logic [5:0] fail_node_ff, nxt_fail_node;
   logic [3:0] fail_cmd_ff, nxt_fail_cmd;
   logic [31:0] mask_ff, nxt_mask;
   logic [15:0] dest_ff, nxt_dest;
   logic vec_pend_ff, nxt_vec_pend;
   logic [15:0] set_vec, clr_vec;
   logic bad_addr, vec_trig, bad_xlate, resp_fail;

   // address range check per translation mode
   always_comb begin
      bad_addr = 1'b0;
      if ((xlate_mode == xlate_none || xlate_mode == xlate_40_8k) && dma_addr[29])
         bad_addr = 1'b1; // see RQ9
      if (xlate_mode == xlate_40_4k && dma_addr[29:28] != 2'b00)
         bad_addr = 1'b1; // see RQ10
      // the A25-A28 window only matters in the 40-bit modes
      if ((xlate_mode == xlate_40_8k || xlate_mode == xlate_40_4k) && dma_addr[28:25] != 4'h0)
         bad_addr = 1'b1; // see RQ10
      bad_addr = bad_addr && dma_req;
   end

   // translate faults only count when a translation mode is active
   assign bad_xlate = xlate_mode != xlate_none;

   // new flag events, one bit per summary bit
   always_comb begin
      set_vec = 16'h0000;
      set_vec[13] = fault.map_corr; // see RQ4
      set_vec[12] = fault.map_fatal; // see RQ5
      set_vec[11] = fault.bad_page; // see RQ6
      set_vec[10] = fault.xlate_corr && bad_xlate; // see RQ7
      set_vec[9] = fault.xlate_fatal && bad_xlate; // see RQ8
      set_vec[8] = bad_addr; // see RQ11
      set_vec[7] = fault.bad_state || fault.map_wr_parity || fault.loop_wr_parity
         || fault.loop_rd_parity; // see RQ12
      set_vec[6] = fault.io_write_fail || fault.map_wr_parity
         || fault.loop_wr_parity; // see RQ12 see RQ14
      set_vec[5] = fault.power_event; // see RQ15
      set_vec[4] = fault.buf_a_data_pe; // see RQ16
      set_vec[3] = fault.buf_a_cmd_pe; // see RQ17
      set_vec[2] = fault.buf_b_data_pe; // see RQ16
      set_vec[1] = fault.buf_b_cmd_pe; // see RQ17
      set_vec[0] = fault.io_read_pe; // see RQ18
   end

   // write-one clears, only on the summary offset
   always_comb begin
      clr_vec = 16'h0000;
      if (req.wr && req.offset == summary_offset)
         clr_vec = req.wdata[15:0] & flag_bits;
   end

   // locks hold while any locking flag is still set
   assign responder_lock = |(flags_ff[13:12]) || flags_ff[7] || flags_ff[6]
      || flags_ff[0]; // see RQ4 see RQ5 see RQ14
   assign bus_addr_lock = |(flags_ff[11:8]); // see RQ6 see RQ11
   assign resp_fail = fault.map_corr || fault.map_fatal || fault.io_write_fail
      || fault.io_read_pe || set_vec[7];

   // summary flags; set beats clear in the same cycle
   always_comb begin
      logic [15:0] others_old;
      logic [15:0] others_new;
      others_old = flags_ff & flag_bits & ~(16'h0001 << power_loss_bit);
      others_new = set_vec & ~(16'h0001 << power_loss_bit);
      nxt_flags = ((flags_ff & ~clr_vec) | set_vec) & flag_bits; // see RQ3
      if (others_new != 16'h0000 && (others_old & ~clr_vec) != 16'h0000)
         nxt_flags[multi_bit] = 1'b1; // see RQ3
      if (self_test_pass && !set_vec[power_loss_bit])
         nxt_flags[power_loss_bit] = 1'b0; // see RQ15
   end

   // failing node and command follow the bus until a responder failure locks them
   always_comb begin
      nxt_fail_node = fail_node_ff;
      nxt_fail_cmd = fail_cmd_ff;
      if (cmd_accept && !responder_lock && !resp_fail) begin
         nxt_fail_node = cmd_node; // see RQ1
         nxt_fail_cmd = cmd_code; // see RQ2
      end
   end

   // mask and destination registers
   always_comb begin
      nxt_mask = mask_ff;
      nxt_dest = dest_ff;
      if (req.wr && req.offset == irq_mask_offset)
         nxt_mask = req.wdata & mask_writable; // see RQ19
      else if (req.wr && req.offset == vector_dest_offset)
         nxt_dest = req.wdata[15:0]; // see RQ23
   end

   // vectored trigger set: unconditional ones plus write-qualified ones
   assign vec_trig = set_vec[7] || set_vec[6] || set_vec[5] || set_vec[4] || set_vec[2]
      || (fault.dma_write && (set_vec[11] || set_vec[9] || set_vec[8] || set_vec[3]
      || set_vec[1] || fault.timeout)); // see RQ13 see RQ20 see RQ21

   // one pending vectored transaction, held until the bus takes it
   always_comb begin
      nxt_vec_pend = vec_pend_ff;
      if (vec_ack)
         nxt_vec_pend = 1'b0;
      if (vec_trig && mask_ff[vec_enable_bit] && dest_ff != 16'h0000)
         nxt_vec_pend = 1'b1; // see RQ20 see RQ11
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         flags_ff <= summary_reset[15:0]; // see RQ15
         fail_node_ff <= 6'h00;
         fail_cmd_ff <= 4'h0;
         mask_ff <= 32'h0000_0000;
         dest_ff <= 16'h0000;
         vec_pend_ff <= 1'b0;
      end else begin
         flags_ff <= nxt_flags;
         fail_node_ff <= nxt_fail_node;
         fail_cmd_ff <= nxt_fail_cmd;
         mask_ff <= nxt_mask;
         dest_ff <= nxt_dest;
         vec_pend_ff <= nxt_vec_pend;
      end
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      rdata = 32'h0000_0000;
      if (req.offset == summary_offset) begin
         rdata[cable_ok_bit] = cable_ok;
         rdata[fail_node_lsb +: 6] = fail_node_ff;
         rdata[fail_cmd_lsb +: 4] = fail_cmd_ff;
         rdata[15:0] = flags_ff;
      end else if (req.offset == irq_mask_offset) begin
         rdata = mask_ff;
      end else if (req.offset == vector_dest_offset) begin
         rdata[15:0] = dest_ff;
      end
   end

   assign error_irq = |(flags_ff[13:0] & {mask_ff[10], mask_ff[9], mask_ff[11:0]}); // see RQ24
   assign vec_irq_req = vec_pend_ff;
   assign vec_irq_dest = dest_ff; // see RQ23
   assign vec_irq_type = write_fault_type; // see RQ13
   assign loop_abort = fault.loop_wr_parity || fault.loop_rd_parity; // see RQ12
   assign read_error_reply = fault.io_read_pe && !fault.dma_write; // see RQ18
   assign use_return_vector = fault.io_read_pe && fault.dma_write; // see RQ18

   // failing node follows each accepted cycle while nothing holds it
   property p_fail_node_follows;
      @(posedge clock) disable iff (!reset_n)
         cmd_accept && !responder_lock && !resp_fail |=> fail_node_ff == $past(cmd_node);
   endproperty
   a_fail_node_follows: assert property (p_fail_node_follows) // see RQ1
      else $error("failing node not captured");

   // failing command must not move while a responder failure is logged
   property p_fail_cmd_frozen;
      @(posedge clock) disable iff (!reset_n)
         responder_lock && !req.wr |=> $stable(fail_cmd_ff);
   endproperty
   a_fail_cmd_frozen: assert property (p_fail_cmd_frozen) // see RQ2
      else $error("failing command changed while locked");

   // a second error on top of an uncleared one marks multiple errors
   property p_multi;
      @(posedge clock) disable iff (!reset_n)
         (|flags_ff[13:6]) && (|set_vec[4:0]) && !req.wr |=> flags_ff[multi_bit];
   endproperty
   a_multi: assert property (p_multi) // see RQ3
      else $error("multiple error not flagged");

   // power loss alone never marks multiple errors
   property p_multi_power;
      @(posedge clock) disable iff (!reset_n)
         set_vec == (16'h0001 << power_loss_bit) && !flags_ff[multi_bit] |=> !flags_ff[multi_bit];
   endproperty
   a_multi_power: assert property (p_multi_power) // see RQ3
      else $error("power loss counted as multiple error");

   // writing one clears a flag when no new event lands in that cycle
   property p_flag_clear;
      @(posedge clock) disable iff (!reset_n)
         req.wr && req.offset == summary_offset && req.wdata[7] && !set_vec[7]
         |=> !flags_ff[7];
   endproperty
   a_flag_clear: assert property (p_flag_clear) // see RQ3
      else $error("write one did not clear the flag");

   // corrected map read sets its flag and holds the responder log
   property p_map_corr;
      @(posedge clock) disable iff (!reset_n)
         fault.map_corr |=> flags_ff[13] && responder_lock;
   endproperty
   a_map_corr: assert property (p_map_corr) // see RQ4
      else $error("map corrected flag missing");

   // fatal map read sets its flag and holds the responder log
   property p_map_fatal;
      @(posedge clock) disable iff (!reset_n)
         fault.map_fatal |=> flags_ff[12] && responder_lock;
   endproperty
   a_map_fatal: assert property (p_map_fatal) // see RQ5
      else $error("map fatal flag missing");

   // invalid map entry sets its flag and holds the bus address log
   property p_bad_page;
      @(posedge clock) disable iff (!reset_n)
         fault.bad_page |=> flags_ff[11] && bus_addr_lock;
   endproperty
   a_bad_page: assert property (p_bad_page) // see RQ6
      else $error("bad page flag missing");

   // translate faults are ignored while no translation runs
   property p_xlate_gate;
      @(posedge clock) disable iff (!reset_n)
         fault.xlate_corr && xlate_mode == xlate_none && !flags_ff[10] && !req.wr
         |=> !flags_ff[10];
   endproperty
   a_xlate_gate: assert property (p_xlate_gate) // see RQ7
      else $error("translate flag set without translation");

   // A29 is out of range without translation
   property p_a29;
      @(posedge clock) disable iff (!reset_n)
         dma_req && xlate_mode == xlate_none && dma_addr[29] |=> flags_ff[8] && bus_addr_lock;
   endproperty
   a_a29: assert property (p_a29) // see RQ9
      else $error("A29 not flagged");

   // A28 is out of range with small pages
   property p_a28_4k;
      @(posedge clock) disable iff (!reset_n)
         dma_req && xlate_mode == xlate_40_4k && dma_addr[28] |=> flags_ff[8];
   endproperty
   a_a28_4k: assert property (p_a28_4k) // see RQ10
      else $error("A28 not flagged with small pages");

   // internal fault raises a vectored request when enabled
   property p_ie_vec;
      @(posedge clock) disable iff (!reset_n)
         fault.bad_state && mask_ff[vec_enable_bit] && dest_ff != 16'h0000 |=> vec_irq_req;
   endproperty
   a_ie_vec: assert property (p_ie_vec) // see RQ13
      else $error("internal fault not vectored");

   // write failure sets its flag and holds the responder log
   property p_write_fail;
      @(posedge clock) disable iff (!reset_n)
         fault.io_write_fail |=> flags_ff[6] && responder_lock;
   endproperty
   a_write_fail: assert property (p_write_fail) // see RQ14
      else $error("write failure flag missing");

   // a power event always sets power loss, even against a self-test clear
   property p_power_event;
      @(posedge clock) disable iff (!reset_n)
         fault.power_event |=> flags_ff[power_loss_bit];
   endproperty
   a_power_event: assert property (p_power_event) // see RQ15
      else $error("power loss not set by event");

   // reset itself counts as a power event
   property p_power_reset;
      @(posedge clock)
         !reset_n |=> flags_ff[power_loss_bit];
   endproperty
   a_power_reset: assert property (p_power_reset) // see RQ15
      else $error("power loss not set by reset");

   // no vectored request unless enabled with a destination
   property p_vec_gate;
      @(posedge clock) disable iff (!reset_n)
         $rose(vec_irq_req) |-> $past(mask_ff[vec_enable_bit]) && $past(dest_ff) != 16'h0000;
   endproperty
   a_vec_gate: assert property (p_vec_gate) // see RQ20
      else $error("vectored request without enable");

   // a pending vectored request stands until the bus takes it
   property p_vec_hold;
      @(posedge clock) disable iff (!reset_n)
         vec_irq_req && !vec_ack |=> vec_irq_req;
   endproperty
   a_vec_hold: assert property (p_vec_hold) // see RQ20
      else $error("vectored request dropped before acknowledge");

   // an unmasked flag keeps the error interrupt up
   property p_irq;
      @(posedge clock) disable iff (!reset_n)
         flags_ff[0] && mask_ff[0] |-> error_irq;
   endproperty
   a_irq: assert property (p_irq) // see RQ24
      else $error("error interrupt missing");

   c_vec: cover property (@(posedge clock) disable iff (!reset_n) vec_irq_req && vec_ack);
   c_multi: cover property (@(posedge clock) disable iff (!reset_n) $rose(flags_ff[multi_bit]));
   c_irq: cover property (@(posedge clock) disable iff (!reset_n) $fell(error_irq));
endmodule

// file: verilog/err_sum_pkg.sv
/*
 error-summary block constants, field positions and carrier structs.
 assumes one 20 MHz clock and a synchronous active-low reset from the host node.
*/
// What this block does
// RQ1 - responder_fail_node bits 25:20 load on each accepted cycle, freeze while error set
// RQ2 - responder_fail_command bits 19:16 load likewise, freeze on failure, release on clear
// RQ3 - multiple_error_flag bit 14 sets on second error; power loss ignored; flags write-one clear
// RQ4 - corrected map read ECC sets bit 13, locks responder address, mask bit 10 interrupts
// RQ5 - fatal map read ECC sets bit 12, locks responder address, mask bit 9 interrupts
// RQ6 - invalid map entry on DMA sets bit 11, locks bus address, mask bit 11 interrupts
// RQ7 - corrected translate fetch sets bit 10 only when translating; mask bit 10
// RQ8 - fatal translate fetch sets bit 9 only when translating; mask bit 9
// RQ9 - no-translation or 40-bit 8K pages: A29 set means invalid address
// RQ10 - 40-bit 4K pages: A28-A29 nonzero invalid; 40-bit: A25-A28 nonzero invalid
// RQ11 - invalid address sets bit 8, locks, mask bit 8; DMA write gets vectored write fault
// RQ12 - internal fault on bad state or parity; map/loopback write parity also sets write failure
// RQ13 - internal fault bit 7 issues vectored write-fault transaction when globally enabled
// RQ14 - I/O write failure bit 6 locks responder address, issues vectored write fault
// RQ15 - power loss bit 5 resets to one, set by power/reset events, vectored, self-test clears
// RQ16 - buffer A/B data parity sets bit 4/2, vectored write fault when enabled
// RQ17 - buffer A/B command parity sets bit 3/1; vectored only on write; mask bits 3/1
// RQ18 - I/O read parity sets bit 0; read error reply or return vector; mask bit 0
// RQ19 - mask register at offset 14 hex gates error interrupt per flag
// RQ20 - vectored transactions only with bit 31 set and destination mask nonzero
// RQ21 - page, fatal DMA ECC, address, command parity, timeout vector only on DMA write
// RQ22 - software must set the global vectored enable for proper reporting
// RQ23 - each destination mask bit selects the matching system bus node
// RQ24 - error interrupt holds while any flag and its mask are both set
package err_sum_pkg;
   localparam logic [7:0] summary_offset = 8'h10;
   localparam logic [7:0] irq_mask_offset = 8'h14;
   localparam logic [7:0] vector_dest_offset = 8'h18;
   localparam int fail_node_lsb = 20;
   localparam int fail_cmd_lsb = 16;
   localparam int multi_bit = 14;
   localparam int power_loss_bit = 5;
   localparam int cable_ok_bit = 31;
   localparam int vec_enable_bit = 31;
   localparam logic [31:0] summary_reset = 32'h8000_0020;
   localparam logic [31:0] mask_writable = 32'h8000_0FFF;
   localparam logic [15:0] flag_bits = 16'h7FFF; // bits 14:0 are write-one-clear flags
   localparam logic [3:0] write_fault_type = 4'h1;

   typedef enum logic [1:0] {xlate_none, xlate_40_8k, xlate_40_4k, xlate_other} xlate_mode_e;

   // one failure report from the datapath, one-cycle pulses
   typedef struct packed {
      logic map_corr;
      logic map_fatal;
      logic bad_page;
      logic xlate_corr;
      logic xlate_fatal;
      logic bad_state;
      logic map_wr_parity;
      logic loop_wr_parity;
      logic loop_rd_parity;
      logic io_write_fail;
      logic power_event;
      logic buf_a_data_pe;
      logic buf_a_cmd_pe;
      logic buf_b_data_pe;
      logic buf_b_cmd_pe;
      logic io_read_pe;
      logic timeout;
      logic dma_write;
   } fault_s;

   // register port request
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] offset;
      logic [31:0] wdata;
   } reg_req_s;
endpackage
